// ### logic/bxm_defines.svh
`ifndef BXM_DEFINES_SVH
`define BXM_DEFINES_SVH

// Register offsets on the plain register port
`define BXM_REG_A 4'h0
`define BXM_REG_B 4'h1
`define BXM_REG_CMD 4'h2
`define BXM_REG_STAT 4'h3
`define BXM_REG_BASE1 4'h4
`define BXM_REG_BASE2 4'h5

// Field positions
`define BXM_CMD_OP 3:0
`define BXM_CMD_LEN 7:4
`define BXM_STAT_BUSY 0
`define BXM_STAT_DC 1
`define BXM_STAT_SE 7:4

// Reset values and mantissa word offset
`define BXM_BASE1_RST 16'h0010
`define BXM_BASE2_RST 16'h0014
`define BXM_MANT_OFS 16'h0001

// Counts
`define BXM_NRM_MAX 5'h0C
`define BXM_FDV_MAX 4'hF
`define BXM_MPY_STEPS 5'h10
`define BXM_LD_LAST 3'h5
`define BXM_WB_LAST 2'h2

`endif

// ### logic/bxm_pkg.sv
package bxm_pkg;

  // Operation codes as written to the command register
  typedef enum logic [3:0]
  {
    block_zero_op,
    block_move_op,
    multi_right_shift_first,
    multi_right_shift_second,
    single_left_shift_second,
    single_right_shift_first,
    normalise_op,
    tens_complement_op,
    fast_multiply_op,
    fast_divide_op,
    booth_multiply_op
  } bxm_op_t;

  // Sequencer states
  typedef enum logic [3:0]
  {
    st_idle,
    st_zero,
    st_mv_rd,
    st_mv_wait,
    st_mv_wr,
    st_ld_rd,
    st_ld_wait,
    st_ld_cap,
    st_exec,
    st_wb
  } bxm_state_t;

endpackage : bxm_pkg

// ### logic/bxm_unit.sv
// Behaviour
// RQ1 - Block zero writes zero to N words from address in A, N 1..16
// RQ2 - Block move copies N words from A onwards to B onwards, ascending
// RQ3 - Multi right shift of first operand, count from B bits 0-3
// RQ4 - First shift inserts A bits 0-3 at top digit, later shifts zero
// RQ5 - Last digit out lands in A bits 0-3, A upper and carry cleared
// RQ6 - After any mantissa shift, shift extend equals A bits 0-3; normalise leaves shift extend and A unchanged
// RQ7 - Multi right shift of second operand behaves like the first one
// RQ8 - Single left shift of second: A into digit 12, digit 1 to A
// RQ9 - Single right shift of first: zero in, digit 12 to A
// RQ10 - Normalise shifts second left until top digit nonzero, max twelve
// RQ11 - Shift count to B bits 0-3; carry set only when count is twelve
// RQ12 - Complement replaces first mantissa with ten's complement, clears carry
// RQ13 - Fast multiply adds first into second B times, carry enters once
// RQ14 - Carry cleared after overflows; overflow count returned in A
// RQ15 - Only mantissa words are touched, sign and exponent left alone
// RQ16 - Booth signed multiply of A and B, high half B, low half A
// RQ17 - Fast divide adds first plus carry into second until overflow; code also stops after fifteen additions without overflow
// RQ18 - Additions without overflow go to B bits 0-3, carry cleared
// RQ19 - Mantissa is twelve BCD digits, digit one most significant
`timescale 1ns/10ps
`include "bxm_defines.svh"

module bxm_unit
  import bxm_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // System memory bus
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic mem_wr,
  output logic mem_rd,
  input wire logic [15:0] mem_rdata,
  // Status
  output logic busy,
  output logic done
);

  // Architectural and working state
  bxm_state_t state;
  bxm_op_t op;
  logic [15:0] a;
  logic [15:0] b;
  logic dc;
  logic [3:0] se;
  logic [15:0] base1;
  logic [15:0] base2;
  logic [0:2][15:0] ar1;
  logic [0:2][15:0] ar2;
  logic [3:0] blk_len;
  logic [3:0] blk_idx;
  logic [2:0] ld_idx;
  logic [1:0] wb_idx;
  logic [4:0] cnt;
  logic [3:0] ovf;
  logic first;
  logic [33:0] booth;

  // Combinational helpers
  logic tgt_first;
  logic [47:0] cur_m;
  logic [47:0] nines1;
  logic [47:0] add_x;
  logic [47:0] add_y;
  logic add_cin;
  logic [47:0] add_sum;
  logic [12:0] add_c;
  logic [1:0] ld_word;
  logic [16:0] booth_up;
  logic [33:0] next_booth;
  logic cmd_ok;

  // Operand that a shift or complement works on
  assign tgt_first = (op == multi_right_shift_first) ||
                     (op == single_right_shift_first) ||
                     (op == tens_complement_op);
  assign cur_m = tgt_first ? ar1 : ar2;
  assign ld_word = (ld_idx < 3'h3) ? ld_idx[1:0] : 2'(ld_idx - 3'h3);
  assign cmd_ok = reg_wdata[`BXM_CMD_OP] <= 4'(booth_multiply_op);

  // Decimal adder, digit 12 in the low nibble, carry ripples upward
  assign add_c[0] = add_cin;
  for (genvar g = 0; g < 12; g++)
  begin : g_dig
    logic [4:0] raw;
    // Word 2 holds digits 9-12, so low nibbles come from the last word
    assign nines1[4*g +: 4] = 4'h9 - ar1[2 - g / 4][4*(g % 4) +: 4];
    assign raw = {1'b0, add_x[4*g +: 4]} + {1'b0, add_y[4*g +: 4]} +
                 {4'h0, add_c[g]};
    assign add_c[g+1] = raw > 5'h09; // RQ19
    assign add_sum[4*g +: 4] = add_c[g+1] ? 4'(raw + 5'h06) : raw[3:0];
  end

  // Adder operands: nines plus one for complement, else second plus first
  always_comb
  begin
    if (op == tens_complement_op)
    begin
      add_x = nines1; // RQ12
      add_y = 48'h0;
      add_cin = 1'b1;
    end
    else
    begin
      add_x = ar2;
      add_y = ar1;
      add_cin = dc; // RQ13 RQ17
    end
  end

  // One radix-2 Booth step: add or subtract B, then arithmetic shift
  always_comb
  begin
    case (booth[1:0])
      2'b01: booth_up = booth[33:17] + {b[15], b};
      2'b10: booth_up = booth[33:17] - {b[15], b};
      default: booth_up = booth[33:17];
    endcase
    next_booth = {booth_up[16], booth_up, booth[16:1]}; // RQ16
  end

  // Sequencer and datapath; software writes land only while idle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= st_idle;
      op <= block_zero_op;
      a <= 16'h0000;
      b <= 16'h0000;
      dc <= 1'b0;
      se <= 4'h0;
      base1 <= `BXM_BASE1_RST;
      base2 <= `BXM_BASE2_RST;
      ar1 <= 48'h0;
      ar2 <= 48'h0;
      blk_len <= 4'h0;
      blk_idx <= 4'h0;
      ld_idx <= 3'h0;
      wb_idx <= 2'h0;
      cnt <= 5'h00;
      ovf <= 4'h0;
      first <= 1'b0;
      booth <= 34'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      case (state)
        st_idle:
        begin
          if (reg_wr)
          begin
            case (reg_addr)
              `BXM_REG_A: a <= reg_wdata;
              `BXM_REG_B: b <= reg_wdata;
              `BXM_REG_STAT:
              begin
                dc <= reg_wdata[`BXM_STAT_DC];
                se <= reg_wdata[`BXM_STAT_SE];
              end
              `BXM_REG_BASE1: base1 <= reg_wdata;
              `BXM_REG_BASE2: base2 <= reg_wdata;
              `BXM_REG_CMD:
              begin
                if (cmd_ok)
                begin
                  op <= bxm_op_t'(reg_wdata[`BXM_CMD_OP]);
                  blk_len <= reg_wdata[`BXM_CMD_LEN];
                  blk_idx <= 4'h0;
                  ld_idx <= 3'h0;
                  wb_idx <= 2'h0;
                  ovf <= 4'h0;
                  first <= 1'b1;
                  busy <= 1'b1;
                  booth <= {17'h0, a, 1'b0};
                  case (bxm_op_t'(reg_wdata[`BXM_CMD_OP]))
                    block_zero_op: state <= st_zero;
                    block_move_op: state <= st_mv_rd;
                    booth_multiply_op:
                    begin
                      cnt <= `BXM_MPY_STEPS;
                      state <= st_exec;
                    end
                    normalise_op:
                    begin
                      cnt <= 5'h00;
                      state <= st_ld_rd;
                    end
                    default:
                    begin
                      cnt <= {1'b0, b[3:0]}; // RQ3 RQ7 RQ13
                      state <= st_ld_rd;
                    end
                  endcase
                end
              end
              default: ;
            endcase
          end
        end
        // One zero write per cycle, ascending
        st_zero:
        begin
          blk_idx <= 4'(blk_idx + 4'h1); // RQ1
          if (blk_idx == blk_len)
          begin
            state <= st_idle;
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
        st_mv_rd: state <= st_mv_wait;
        st_mv_wait: state <= st_mv_wr;
        // Word read two cycles ago is written out now
        st_mv_wr:
        begin
          blk_idx <= 4'(blk_idx + 4'h1); // RQ2
          if (blk_idx == blk_len)
          begin
            state <= st_idle;
            busy <= 1'b0;
            done <= 1'b1;
          end
          else
            state <= st_mv_rd;
        end
        st_ld_rd: state <= st_ld_wait;
        st_ld_wait: state <= st_ld_cap;
        // Capture one mantissa word, first operand then second
        st_ld_cap:
        begin
          if (ld_idx < 3'h3)
            ar1[ld_word] <= mem_rdata;
          else
            ar2[ld_word] <= mem_rdata;
          ld_idx <= 3'(ld_idx + 3'h1);
          state <= (ld_idx == `BXM_LD_LAST) ? st_exec : st_ld_rd;
        end
        st_exec:
        begin
          state <= st_wb;
          case (op)
            multi_right_shift_first, multi_right_shift_second:
            begin
              if (cnt == 5'h00)
                se <= a[3:0]; // RQ6
              else
              begin
                if (tgt_first)
                  ar1 <= {first ? a[3:0] : 4'h0, cur_m[47:4]}; // RQ4
                else
                  ar2 <= {first ? a[3:0] : 4'h0, cur_m[47:4]}; // RQ7
                first <= 1'b0;
                cnt <= 5'(cnt - 5'h01);
                if (cnt == 5'h01)
                begin
                  a <= {12'h000, cur_m[3:0]}; // RQ5
                  dc <= 1'b0;
                  se <= cur_m[3:0]; // RQ6
                end
                else
                  state <= st_exec;
              end
            end
            single_left_shift_second:
            begin
              ar2 <= {cur_m[43:0], a[3:0]}; // RQ8
              a <= {12'h000, cur_m[47:44]};
              dc <= 1'b0;
              se <= cur_m[47:44]; // RQ6
            end
            single_right_shift_first:
            begin
              ar1 <= {4'h0, cur_m[47:4]}; // RQ9
              a <= {12'h000, cur_m[3:0]};
              dc <= 1'b0;
              se <= cur_m[3:0]; // RQ6
            end
            normalise_op:
            begin
              if (cur_m[47:44] != 4'h0 || cnt == `BXM_NRM_MAX)
              begin
                b <= {12'h000, cnt[3:0]}; // RQ11
                dc <= (cnt == `BXM_NRM_MAX);
              end
              else
              begin
                ar2 <= {cur_m[43:0], 4'h0}; // RQ10
                cnt <= 5'(cnt + 5'h01);
                state <= st_exec;
              end
            end
            tens_complement_op:
            begin
              ar1 <= add_sum; // RQ12
              dc <= 1'b0;
            end
            fast_multiply_op:
            begin
              dc <= 1'b0; // RQ14
              if (cnt == 5'h00)
                a <= {12'h000, ovf}; // RQ14
              else
              begin
                ar2 <= add_sum; // RQ13
                if (add_c[12])
                  ovf <= 4'(ovf + 4'h1);
                cnt <= 5'(cnt - 5'h01);
                state <= st_exec;
              end
            end
            fast_divide_op:
            begin
              ar2 <= add_sum; // RQ17
              if (add_c[12])
              begin
                b <= {12'h000, ovf}; // RQ18
                dc <= 1'b0;
              end
              else if (4'(ovf + 4'h1) == `BXM_FDV_MAX)
              begin
                b <= {12'h000, `BXM_FDV_MAX};
                dc <= 1'b0;
              end
              else
              begin
                ovf <= 4'(ovf + 4'h1);
                state <= st_exec;
              end
            end
            booth_multiply_op:
            begin
              booth <= next_booth;
              cnt <= 5'(cnt - 5'h01);
              if (cnt == 5'h01)
              begin
                b <= next_booth[32:17]; // RQ16
                a <= next_booth[16:1];
                state <= st_idle;
                busy <= 1'b0;
                done <= 1'b1;
              end
              else
                state <= st_exec;
            end
            default: state <= st_idle;
          endcase
        end
        // Three mantissa words of the changed operand go back
        st_wb:
        begin
          wb_idx <= 2'(wb_idx + 2'h1);
          if (wb_idx == `BXM_WB_LAST)
          begin
            state <= st_idle;
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // Memory bus strobes, one cycle each, driven from the sequencer state
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
    end
    else if (ce)
    begin
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      case (state)
        st_zero:
        begin
          mem_wr <= 1'b1;
          mem_addr <= 16'(a + {12'h000, blk_idx}); // RQ1
          mem_wdata <= 16'h0000;
        end
        st_mv_rd:
        begin
          mem_rd <= 1'b1;
          mem_addr <= 16'(a + {12'h000, blk_idx}); // RQ2
        end
        st_mv_wr:
        begin
          mem_wr <= 1'b1;
          mem_addr <= 16'(b + {12'h000, blk_idx}); // RQ2
          mem_wdata <= mem_rdata;
        end
        st_ld_rd:
        begin
          mem_rd <= 1'b1;
          mem_addr <= 16'(((ld_idx < 3'h3) ? base1 : base2) +
                      `BXM_MANT_OFS + {14'h0000, ld_word}); // RQ15
        end
        st_wb:
        begin
          mem_wr <= 1'b1;
          mem_addr <= 16'((tgt_first ? base1 : base2) +
                      `BXM_MANT_OFS + {14'h0000, wb_idx}); // RQ15
          mem_wdata <= tgt_first ? ar1[wb_idx] : ar2[wb_idx];
        end
        default: ;
      endcase
    end
  end

  // Register read data, valid only in the cycle after the read strobe
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 16'h0000;
    else if (ce)
    begin
      reg_rdata <= 16'h0000;
      if (reg_rd)
      begin
        case (reg_addr)
          `BXM_REG_A: reg_rdata <= a;
          `BXM_REG_B: reg_rdata <= b;
          `BXM_REG_CMD: reg_rdata <= {8'h00, blk_len, 4'(op)};
          `BXM_REG_STAT: reg_rdata <= {8'h00, se, 2'b00, dc, busy};
          `BXM_REG_BASE1: reg_rdata <= base1;
          `BXM_REG_BASE2: reg_rdata <= base2;
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule : bxm_unit

// ### test/bxm_unit_monitor.sv
`timescale 1ns/10ps
`include "bxm_defines.svh"

module bxm_unit_monitor
  import bxm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Memory bus
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [15:0] mem_rdata,
  // Status
  input wire logic busy,
  input wire logic done
);
  logic [3:0] op_q;
  logic [4:0] n_q;
  logic [4:0] wcnt;
  logic start;

  // Command write that the unit must accept
  assign start = ce && reg_wr && reg_addr == `BXM_REG_CMD && !busy
    && reg_wdata[3:0] <= 4'hA;

  // Operation, word count and memory writes since the last start
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      op_q <= 4'hF;
      n_q <= 5'h00;
      wcnt <= 5'h00;
    end
    else if (start)
    begin
      op_q <= reg_wdata[3:0];
      n_q <= {1'b0, reg_wdata[7:4]} + 5'h01;
      wcnt <= 5'h00;
    end
    else if (mem_wr)
      wcnt <= wcnt + 5'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_start_busy:
    assert property (start |=> busy)
    else $error("busy did not follow a command");
  a_busy_ends:
    assert property ($rose(busy) |-> ##[1:400] done)
    else $error("operation did not finish");
  a_read_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside the answer cycle");
  a_zero_word:
    assert property (mem_wr && op_q == block_zero_op |-> mem_wdata == 0)
    else $error("block zero wrote nonzero data");
  a_zero_ascend:
    assert property (mem_wr && op_q == block_zero_op && $past(mem_wr)
      |-> mem_addr == $past(mem_addr) + 16'h0001)
    else $error("block zero address not ascending");
  a_move_copy:
    assert property (mem_rd && op_q == block_move_op
      |-> ##2 (mem_wr && mem_wdata == $past(mem_rdata)))
    else $error("block move did not copy the word read");
  a_word_count:
    assert property (done && op_q <= 4'h1
      |-> wcnt + {4'h0, mem_wr} == n_q)
    else $error("block operation word count wrong");
  a_bcd_burst:
    assert property (mem_wr && !$past(mem_wr) && op_q inside {[2:9]}
      |-> ##1 mem_wr ##1 mem_wr ##1 !mem_wr)
    else $error("mantissa writeback not three words");
  a_booth_quiet:
    assert property (busy && op_q == booth_multiply_op
      |-> !mem_rd && !mem_wr)
    else $error("binary multiply used the memory bus");

  c_move: cover property (done && op_q == block_move_op);
  c_divide: cover property (done && op_q == fast_divide_op);
  c_booth: cover property (start && reg_wdata[3:0] == 4'hA);
endmodule : bxm_unit_monitor

bind bxm_unit bxm_unit_monitor u_mon
(
  .clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
  .busy(busy), .done(done)
);

// ### test/bxm_mem_model.sv
`timescale 1ns/10ps

module bxm_mem_model
(
  // Clock
  input wire logic clk,
  // Memory bus from the unit
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_wr,
  input wire logic mem_rd,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [0:255];

  // Word answers in the cycle after the strobe; otherwise the bus toggles
  // so that stale data can never pass for an answer
  always @(posedge clk)
  begin
    if (mem_wr)
      mem[mem_addr[7:0]] <= mem_wdata;
    if (mem_rd)
      mem_rdata <= mem[mem_addr[7:0]];
    else
      mem_rdata <= ~mem_rdata;
  end

  initial mem_rdata = 16'h0000;
endmodule : bxm_mem_model

// ### test/bxm_unit_bench.sv
`timescale 1ns/10ps
`include "bxm_defines.svh"

module bxm_unit_bench
  import bxm_pkg::*;
;
  localparam int P1 = `BXM_BASE1_RST;
  localparam int P2 = `BXM_BASE2_RST;
  logic clk, nrst, ce, reg_wr, reg_rd, mem_wr, mem_rd, busy, done;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata;
  int fail_count = 0;
  int tests_run = 0;

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Unit and memory
  bxm_unit u_dut
  (
    .clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .busy(busy), .done(done)
  );
  bxm_mem_model u_mem
  (
    .clk(clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata)
  );

  task chk16(input string nm, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk16

  task chk48(input string nm, input logic [47:0] e, input logic [47:0] s);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk48

  // One-cycle register write
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Register read, data taken in the answer cycle, then compared
  task rchk(input string nm, input logic [3:0] a, input logic [15:0] e,
    input logic [15:0] msk);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk16(nm, e, reg_rdata & msk);
  endtask : rchk

  // Waits for the completion pulse under a bound
  task wait_done;
    int i;
    i = 0;
    while (done !== 1'b1 && i < 500)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    chk16("done", 16'h0001, {15'h0000, done});
    // The last memory write goes out with done and lands one edge later
    @(posedge clk);
    #1;
  endtask : wait_done

  function automatic logic [47:0] mant(input int p);
    return {u_mem.mem[p+1], u_mem.mem[p+2], u_mem.mem[p+3]};
  endfunction : mant

  // Loads both operands, runs one operation and checks every result
  task bcd(input logic [3:0] op, input logic [47:0] m1,
    input logic [47:0] m2, input logic [15:0] a, input logic [15:0] b,
    input logic [15:0] st, input logic [47:0] e1, input logic [47:0] e2,
    input logic [15:0] ea, input logic [15:0] eb, input logic [15:0] es,
    input logic [15:0] sm);
    u_mem.mem[P1] = 16'hA5A5;
    u_mem.mem[P2] = 16'h5A5A;
    {u_mem.mem[P1+1], u_mem.mem[P1+2], u_mem.mem[P1+3]} = m1;
    {u_mem.mem[P2+1], u_mem.mem[P2+2], u_mem.mem[P2+3]} = m2;
    wr(`BXM_REG_A, a);
    wr(`BXM_REG_B, b);
    wr(`BXM_REG_STAT, st);
    wr(`BXM_REG_CMD, {12'h000, op});
    wait_done;
    chk48("first", e1, mant(P1));
    chk48("second", e2, mant(P2));
    chk16("sign1", 16'hA5A5, u_mem.mem[P1]);
    chk16("sign2", 16'h5A5A, u_mem.mem[P2]);
    rchk("reg_a", `BXM_REG_A, ea, 16'hFFFF);
    rchk("reg_b", `BXM_REG_B, eb, 16'hFFFF);
    rchk("status", `BXM_REG_STAT, es, sm);
  endtask : bcd

  // Reset values, unmapped read and a refused op code
  task t_reset;
    rchk("reg_a", `BXM_REG_A, 16'h0000, 16'hFFFF);
    rchk("reg_b", `BXM_REG_B, 16'h0000, 16'hFFFF);
    rchk("status", `BXM_REG_STAT, 16'h0000, 16'hFFFF);
    rchk("base1", `BXM_REG_BASE1, `BXM_BASE1_RST, 16'hFFFF);
    rchk("base2", `BXM_REG_BASE2, `BXM_BASE2_RST, 16'hFFFF);
    rchk("unmapped", 4'hF, 16'h0000, 16'hFFFF);
    wr(`BXM_REG_CMD, 16'h000B);
    rchk("busy", `BXM_REG_STAT, 16'h0000, 16'h0001);
    // A write while the clock enable is low must be lost
    ce <= 1'b0;
    wr(`BXM_REG_A, 16'h1234);
    ce <= 1'b1;
    rchk("frozen", `BXM_REG_A, 16'h0000, 16'hFFFF);
    $display("test reset finished");
  endtask : t_reset

  // Sixteen words zeroed, neighbours kept, write while busy ignored
  task t_zero;
    for (int i = 8'h3F; i <= 8'h50; i++)
      u_mem.mem[i] = 16'h1111;
    wr(`BXM_REG_A, 16'h0040);
    wr(`BXM_REG_CMD, 16'h00F0);
    wr(`BXM_REG_A, 16'hFFFF);
    wait_done;
    for (int i = 8'h40; i <= 8'h4F; i++)
      chk16("zeroed", 16'h0000, u_mem.mem[i]);
    chk16("below", 16'h1111, u_mem.mem[8'h3F]);
    chk16("above", 16'h1111, u_mem.mem[8'h50]);
    rchk("reg_a", `BXM_REG_A, 16'h0040, 16'hFFFF);
    $display("test zero finished");
  endtask : t_zero

  // Three words copied in order, the fourth target left alone
  task t_move;
    for (int i = 0; i < 4; i++)
      u_mem.mem[8'h60 + i] = 16'h6000 + 16'(i);
    u_mem.mem[8'h73] = 16'hEEEE;
    wr(`BXM_REG_A, 16'h0060);
    wr(`BXM_REG_B, 16'h0070);
    wr(`BXM_REG_CMD, 16'h0021);
    wait_done;
    for (int i = 0; i < 3; i++)
      chk16("copy", 16'h6000 + 16'(i), u_mem.mem[8'h70 + i]);
    chk16("past end", 16'hEEEE, u_mem.mem[8'h73]);
    rchk("reg_b", `BXM_REG_B, 16'h0070, 16'hFFFF);
    $display("test move finished");
  endtask : t_move

  // Mantissa shifts and normalisation
  task t_shift;
    bcd(4'h2, 48'h123456789012, 48'h111111111111, 16'h0005, 16'h0002,
      16'h0002, 48'h051234567890, 48'h111111111111, 16'h0001, 16'h0002,
      16'h0010, 16'h00FF);
    bcd(4'h3, 48'h111111111111, 48'h987654321098, 16'h1237, 16'hFFF1,
      16'h0000, 48'h111111111111, 48'h798765432109, 16'h0008, 16'hFFF1,
      16'h0080, 16'h00FF);
    bcd(4'h4, 48'h111111111111, 48'h123456789012, 16'hABC9, 16'h0000,
      16'h0002, 48'h111111111111, 48'h234567890129, 16'h0001, 16'h0000,
      16'h0010, 16'h00FF);
    bcd(4'h5, 48'h123456789012, 48'h111111111111, 16'hFFFF, 16'h0000,
      16'h0002, 48'h012345678901, 48'h111111111111, 16'h0002, 16'h0000,
      16'h0020, 16'h00FF);
    bcd(4'h6, 48'h111111111111, 48'h000456789012, 16'h0000, 16'hFFFF,
      16'h0002, 48'h111111111111, 48'h456789012000, 16'h0000, 16'h0003,
      16'h0000, 16'h000F);
    bcd(4'h6, 48'h111111111111, 48'h000000000000, 16'h0000, 16'hFFFF,
      16'h0000, 48'h111111111111, 48'h000000000000, 16'h0000, 16'h000C,
      16'h0002, 16'h000F);
    $display("test shift finished");
  endtask : t_shift

  // Decimal complement, then multiply and divide with overflow out of the top digit
  task t_arith;
    bcd(4'h7, 48'h123456789012, 48'h111111111111, 16'h0000, 16'h0000,
      16'h0002, 48'h876543210988, 48'h111111111111, 16'h0000, 16'h0000,
      16'h0000, 16'h000F);
    bcd(4'h8, 48'h300000000000, 48'h100000000000, 16'hFFFF, 16'h0004,
      16'h0002, 48'h300000000000, 48'h300000000001, 16'h0001, 16'h0004,
      16'h0000, 16'h000F);
    bcd(4'h9, 48'h400000000000, 48'h100000000000, 16'h0000, 16'hFFFF,
      16'h0002, 48'h400000000000, 48'h300000000003, 16'h0000, 16'h0002,
      16'h0000, 16'h000F);
    $display("test arith finished");
  endtask : t_arith

  // Signed products split over B and A
  task t_mpy;
    bcd(4'hA, 48'h1, 48'h2, 16'hFFFD, 16'h0007, 16'h0000, 48'h1, 48'h2,
      16'hFFEB, 16'hFFFF, 16'h0000, 16'h000F);
    bcd(4'hA, 48'h1, 48'h2, 16'h7FFF, 16'h8000, 16'h0000, 48'h1, 48'h2,
      16'h8000, 16'hC000, 16'h0000, 16'h000F);
    $display("test multiply finished");
  endtask : t_mpy

  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // Main sequence
  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_zero;
    t_move;
    t_shift;
    t_arith;
    t_mpy;
    finish_test;
  end

  // Watchdog well beyond the several hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test;
  end
endmodule : bxm_unit_bench
